//--- alarm_asserts.sv
`timescale 1ns/10ps
module alarm_asserts #(
	parameter int LANES = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [LANES-1:0] lane_fifo_fault,
	input wire logic serializer_pll_unlock,
	input wire logic link_state_fault,
	input wire logic clock_realign,
	input wire logic divider_mismatch,
	input wire logic alarm_irq
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wire fault = |lane_fifo_fault | serializer_pll_unlock | link_state_fault
		| clock_realign | divider_mismatch;
	// ==========================================================
	// bus
	a_b_holds: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
	a_r_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
	a_read_turn: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("read late");
	a_rdata_upper: assert property (s_axi_rvalid
		|-> s_axi_rdata[31:8] == 24'h0) else $error("rdata upper set");
	a_write_busy: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready) else $error("ready in b");
	// ==========================================================
	// alarm
	a_irq_reset: assert property ($rose(aresetn) |-> !alarm_irq)
		else $error("irq after reset");
	a_irq_rise: assert property ($rose(alarm_irq)
		|-> $past(fault) || $past(s_axi_bvalid)) else $error("irq no cause");
	a_irq_fall: assert property ($fell(alarm_irq)
		|-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("irq fell");
	c_irq: cover property ($rose(alarm_irq));
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule // alarm_asserts

bind alarm_mask_and_lane_fifo_flags alarm_asserts #(.LANES(LANES)) u_chk (
	.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .lane_fifo_fault,
	.serializer_pll_unlock, .link_state_fault, .clock_realign,
	.divider_mismatch, .alarm_irq);

//--- alarm_mask_and_lane_fifo_flags.sv
`timescale 1ns/10ps
module alarm_mask_and_lane_fifo_flags #(
	parameter int ADDR_W = 12,
	parameter int LANES = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// alarm sources, levels sampled every clock; cal_status feeds the pin while cal_sel is 0
	input wire logic [LANES-1:0] lane_fifo_fault,
	input wire logic serializer_pll_unlock,
	input wire logic link_state_fault,
	input wire logic clock_realign,
	input wire logic divider_mismatch,
	input wire logic cal_status,
	// outputs
	output logic alarm_irq,
	output logic cal_status_output_pin
);

	// ==========================================================
	// helpers
	function automatic logic [9:0] reg_index(input logic [ADDR_W-1:0] a);
		reg_index = 10'(a[ADDR_W-1:2]);
	endfunction

	function automatic logic is_mapped(input logic [9:0] idx);
		is_mapped = (idx == alarm_pkg::IDX_ALARM) ||
			(idx == alarm_pkg::IDX_STATUS) ||
			(idx == alarm_pkg::IDX_MASK) ||
			(idx == alarm_pkg::IDX_LANE) ||
			(idx == alarm_pkg::IDX_CTRL);
	endfunction

	function automatic logic wr_hit(input logic en, input logic [9:0] idx,
			input logic [9:0] target);
		wr_hit = en && (idx == target);
	endfunction

	// ==========================================================
	// state
	logic [7:0] alarm_source_mask;
	logic [7:0] alarm_flag_register;
	logic [LANES-1:0] lane_fifo_fault_flags;
	logic cal_sel;
	logic alarm_summary;

	logic aw_full;
	logic w_full;
	logic [9:0] aw_idx;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_en;
	logic [9:0] wr_idx;
	logic [7:0] wr_byte;
	logic wr_mask;
	logic wr_ctrl;
	logic wr_status;
	logic wr_lane;

	logic [7:0] next_status;
	logic [LANES-1:0] next_lane;
	logic [7:0] status_set;
	logic [7:0] status_clr;
	logic [LANES-1:0] lane_clr;
	logic next_alarm;
	logic [9:0] rd_idx;
	logic [31:0] rd_word;

	// ==========================================================
	// write channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			aw_full <= 1'b0;
			aw_idx <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_full <= 1'b1;
			aw_idx <= reg_index(s_axi_awaddr);
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
			aw_full <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b1;
			w_full <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_full <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
			w_full <= 1'b0;
		end
	end

	// both halves held: commit once, then answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
		end else if (aw_full && w_full && !s_axi_bvalid) begin
			s_axi_bvalid <= 1'b1;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// unmapped indices answer with an error, nothing changes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bresp <= alarm_pkg::RESP_OKAY;
		end else if (aw_full && w_full && !s_axi_bvalid) begin
			s_axi_bresp <= is_mapped(aw_idx) ? alarm_pkg::RESP_OKAY :
				alarm_pkg::RESP_SLVERR;
		end
	end

	always_comb begin
		wr_en = aw_full && w_full && !s_axi_bvalid && w_strb[0];
		wr_idx = aw_idx;
		wr_byte = w_data[7:0];
	end

	// ==========================================================
	// write decode, one strobe per writable register
	always_comb begin
		wr_mask = wr_hit(wr_en, wr_idx, alarm_pkg::IDX_MASK);
		wr_ctrl = wr_hit(wr_en, wr_idx, alarm_pkg::IDX_CTRL);
		wr_status = wr_hit(wr_en, wr_idx, alarm_pkg::IDX_STATUS);
		wr_lane = wr_hit(wr_en, wr_idx, alarm_pkg::IDX_LANE);
	end

	// ==========================================================
	// read channel
	always_comb begin
		rd_idx = reg_index(s_axi_araddr);
		// unmapped indices read as zero
		unique case (rd_idx)
			alarm_pkg::IDX_ALARM: rd_word = {31'h0, alarm_summary};
			alarm_pkg::IDX_STATUS: rd_word = {24'h0, alarm_flag_register};
			alarm_pkg::IDX_MASK: rd_word = {24'h0, alarm_source_mask};
			alarm_pkg::IDX_LANE: rd_word = 32'(lane_fifo_fault_flags);
			alarm_pkg::IDX_CTRL: rd_word = {31'h0, cal_sel};
			default: rd_word = 32'h0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
		end
	end

	// payload captured with the address, held until taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rdata <= '0;
			s_axi_rresp <= alarm_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rdata <= rd_word;
			s_axi_rresp <= is_mapped(rd_idx) ? alarm_pkg::RESP_OKAY :
				alarm_pkg::RESP_SLVERR;
		end
	end

	// ==========================================================
	// mask and control
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_source_mask <= alarm_pkg::MASK_RESET;
		end else if (wr_mask) begin
			// reserved bits stored as written
			alarm_source_mask <= wr_byte;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cal_sel <= alarm_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			cal_sel <= wr_byte[alarm_pkg::BIT_CAL_SEL];
		end
	end

	// ==========================================================
	// status flags: set wins over clear
	always_comb begin
		status_set = 8'h0;
		status_set[alarm_pkg::BIT_FIFO] = |lane_fifo_fault;
		status_set[alarm_pkg::BIT_PLL] = serializer_pll_unlock;
		status_set[alarm_pkg::BIT_LINK] = link_state_fault;
		status_set[alarm_pkg::BIT_REALIGN] = clock_realign;
		status_set[alarm_pkg::BIT_DIV] = divider_mismatch;
		status_clr = wr_status ? wr_byte : 8'h0;
		// mask plays no part here
		next_status = ((alarm_flag_register & ~status_clr) | status_set) &
			alarm_pkg::STATUS_STORED;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_flag_register <= alarm_pkg::STATUS_RESET;
		end else begin
			alarm_flag_register <= next_status;
		end
	end

	// ==========================================================
	// per-lane fifo fault flags
	always_comb begin
		lane_clr = '0;
		if (wr_lane) begin
			lane_clr = wr_byte[LANES-1:0];
		end
		if (wr_status && wr_byte[alarm_pkg::BIT_FIFO]) begin
			lane_clr = '1;
		end
		// persisting fault re-sets in the same cycle
		next_lane = (lane_fifo_fault_flags & ~lane_clr) | lane_fifo_fault;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lane_fifo_fault_flags <= alarm_pkg::LANE_RESET[LANES-1:0];
		end else begin
			lane_fifo_fault_flags <= next_lane;
		end
	end

	// ==========================================================
	// summary alarm, interrupt and pin
	always_comb begin
		next_alarm = |(next_status & ~alarm_source_mask &
			alarm_pkg::ALARM_SOURCES);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_summary <= 1'b0;
		end else begin
			alarm_summary <= next_alarm;
		end
	end

	// interrupt mirrors the alarm bit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_irq <= 1'b0;
		end else begin
			alarm_irq <= next_alarm;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cal_status_output_pin <= 1'b0;
		end else begin
			cal_status_output_pin <= cal_sel ? next_alarm : cal_status;
		end
	end

endmodule // alarm_mask_and_lane_fifo_flags

//--- alarm_pkg.sv
package alarm_pkg;

	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [9:0] IDX_ALARM = 10'h2c0;
	localparam logic [9:0] IDX_STATUS = 10'h2c1;
	localparam logic [9:0] IDX_MASK = 10'h2c2;
	localparam logic [9:0] IDX_LANE = 10'h2c4;
	localparam logic [9:0] IDX_CTRL = 10'h2c8;

	// ==========================================================
	// field positions
	localparam int BIT_FIFO = 5;
	localparam int BIT_PLL = 4;
	localparam int BIT_LINK = 3;
	localparam int BIT_REALIGN = 2;
	localparam int BIT_RSVD = 1;
	localparam int BIT_DIV = 0;
	localparam int BIT_CAL_SEL = 0;

	// ==========================================================
	// reset values and field masks
	localparam logic [7:0] MASK_RESET = 8'h3f;
	localparam logic [7:0] STATUS_RESET = 8'h3f;
	localparam logic [7:0] LANE_RESET = 8'hff;
	localparam logic [7:0] STATUS_STORED = 8'h3f;
	localparam logic [7:0] ALARM_SOURCES = 8'h3d;
	localparam logic CTRL_RESET = 1'b0;

	// ==========================================================
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- test_alarm_mask_and_lane_fifo_flags.sv
`timescale 1ns/10ps
module test_alarm_mask_and_lane_fifo_flags;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bq = 0, arv = 0, rq = 0;
	logic cal = 0;
	logic [11:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, d;
	logic [7:0] lane = 0;
	logic [5:0] src = 0;
	logic [1:0] q;
	wire awr, wrd, bv, arr, rv, irq, pin;
	wire [1:0] br, rr;
	wire [31:0] rdat;
	int fail_count = 0, num_checks = 0;
	alarm_mask_and_lane_fifo_flags dut_u (.aclk, .aresetn,
		.s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bq), .s_axi_araddr(ara),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rq), .lane_fifo_fault(lane | {7'h0, src[5]}),
		.serializer_pll_unlock(src[4]), .link_state_fault(src[3]),
		.clock_realign(src[2]), .divider_mismatch(src[0]),
		.cal_status(cal), .alarm_irq(irq), .cal_status_output_pin(pin));
	initial forever #50 aclk = ~aclk;
	// ==========================================================
	// bus and compare helpers
	task automatic bus_wr(input logic [9:0] i, input logic [7:0] v);
		@(posedge aclk);
		awa <= {i, 2'h0};
		wd <= {24'h0, v};
		awv <= 1'b1;
		wv <= 1'b1;
		bq <= 1'b1;
		do begin
			@(posedge aclk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
		end while (bv !== 1'b1);
		q = br;
		bq <= 1'b0;
	endtask
	task automatic bus_rd(input logic [9:0] i);
		@(posedge aclk);
		ara <= {i, 2'h0};
		arv <= 1'b1;
		rq <= 1'b1;
		do begin
			@(posedge aclk);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		d = rdat;
		q = rr;
		rq <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h, want %h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset();
		bus_rd(alarm_pkg::IDX_MASK);
		chk(d, 32'h3f);
		bus_rd(alarm_pkg::IDX_LANE);
		chk(d, 32'hff);
		bus_rd(alarm_pkg::IDX_STATUS);
		chk(d, 32'h3f);
		bus_rd(alarm_pkg::IDX_ALARM);
		chk({d[30:0], irq}, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_lane();
		bus_wr(alarm_pkg::IDX_LANE, 8'h0f);
		chk(q, {30'h0, alarm_pkg::RESP_OKAY});
		bus_rd(alarm_pkg::IDX_LANE);
		chk(d, 32'hf0);
		bus_wr(alarm_pkg::IDX_LANE, 8'h00);
		bus_rd(alarm_pkg::IDX_LANE);
		chk(d, 32'hf0);
		lane <= 8'h04;
		bus_wr(alarm_pkg::IDX_LANE, 8'hff);
		bus_rd(alarm_pkg::IDX_LANE);
		chk(d, 32'h04);
		lane <= 8'h00;
		bus_wr(alarm_pkg::IDX_STATUS, 8'h3f);
		bus_rd(alarm_pkg::IDX_LANE);
		chk(d, 32'h0);
		lane <= 8'h40;
		@(posedge aclk);
		lane <= 8'h00;
		bus_rd(alarm_pkg::IDX_STATUS);
		chk(d, 32'h20);
		bus_rd(alarm_pkg::IDX_LANE);
		chk(d, 32'h40);
		$display("lane test done");
	endtask
	task automatic t_mask();
		bus_wr(alarm_pkg::IDX_STATUS, 8'h3f);
		bus_wr(alarm_pkg::IDX_MASK, 8'h02);
		for (int k = 0; k < 6; k++) begin
			if (k == 1) continue;
			src[k] <= 1'b1;
			@(posedge aclk);
			src[k] <= 1'b0;
			bus_rd(alarm_pkg::IDX_ALARM);
			chk({d[30:0], irq}, 32'h3);
			bus_wr(alarm_pkg::IDX_MASK, 8'h02 | (8'h1 << k));
			bus_rd(alarm_pkg::IDX_ALARM);
			chk({d[30:0], irq}, 32'h0);
			bus_rd(alarm_pkg::IDX_STATUS);
			chk(d, 32'h1 << k);
			bus_wr(alarm_pkg::IDX_MASK, 8'h02);
			bus_wr(alarm_pkg::IDX_STATUS, 8'h3f);
			bus_rd(alarm_pkg::IDX_ALARM);
			chk({d[30:0], irq}, 32'h0);
		end
		$display("mask test done");
	endtask
	task automatic t_cal();
		bus_wr(alarm_pkg::IDX_CTRL, 8'h01);
		src[4] <= 1'b1;
		@(posedge aclk);
		src[4] <= 1'b0;
		bus_rd(alarm_pkg::IDX_ALARM);
		chk({pin, irq}, 32'h3);
		bus_wr(alarm_pkg::IDX_STATUS, 8'h10);
		bus_rd(alarm_pkg::IDX_ALARM);
		chk({pin, irq}, 32'h0);
		bus_wr(alarm_pkg::IDX_CTRL, 8'h00);
		cal <= 1'b1;
		bus_rd(10'h3ff);
		chk({pin, q}, {1'b1, alarm_pkg::RESP_SLVERR});
		chk(d, 32'h0);
		bus_wr(10'h3fe, 8'hff);
		chk(q, {30'h0, alarm_pkg::RESP_SLVERR});
		$display("cal pin test done");
	endtask
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_lane();
		t_mask();
		t_cal();
		tally_and_finish();
	end
	initial begin
		#2000000;
		fail_count++;
		tally_and_finish();
	end
endmodule // test_alarm_mask_and_lane_fifo_flags
